// ---- core/arb_consts.svh ----
// Offsets, field positions, reset values and codes for the dual arbiter control word.
// Assumes bit 31 of the register word is the most significant data bit.
`ifndef ARB_CONSTS_SVH
`define ARB_CONSTS_SVH

`define ARB_WORD_ADDR     32'hFEFF000C
`define ARB_RW_MASK       32'hFF70FFC0
`define ARB_RESET_CFG     32'h00000000

`define FBR_POS           30
`define FSR_POS           28
`define FBW_POS           26
`define FSW_POS           24
`define CPU_PRI_POS       22
`define CPU_PRK_POS       20
`define CPU_ENA_POS       16
`define PCI_SCH_POS       14
`define PCI_PRK_POS       10
`define PCI_PRIORITY_ORDER_CODE_POS      7
`define PCI_POL_POS       6
`define PCI_ENA_POS       0

`define FLAT_ALWAYS       2'h2
`define FLAT_SWITCH       2'h3
`define CPU_PARK_NONE     2'h0
`define CPU_PARK_LAST     2'h1
`define CPU_PARK_CPU0     2'h2
`define CPU_PARK_CPU1     2'h3

`define PCI_SCH_FIXED     2'h0
`define PCI_SCH_RR        2'h1
`define PCI_SCH_MIXED     2'h2
`define PCI_SCH_RSVD      2'h3
`define PCI_PARK_LAST     4'h0
`define PCI_PARK_BRIDGE   4'h8
`define PCI_PARK_NONE     4'hF
`define PCI_BRIDGE_ID     3'h7
`define PCI_RING_TOP      3'h7

`endif

// ---- core/arb_pkg.sv ----
// Types shared by the arbiter control block and its priority picker.
// Assumes the constants header is compiled alongside.
package arb_pkg;

  typedef logic [2:0]      pci_id_t;
  typedef logic [7:0][2:0] pci_order_t;

  typedef enum logic {PCI_FREE, PCI_LOCKED} pci_lock_state_t;

  typedef struct packed {
    logic [31:0]     cfg;
    logic            cpu_ena;
    logic            pci_ena;
    logic            strap_done;
    logic [31:0]     rdata;
    logic            ack;
    logic [2:0]      cpu_gnt;
    logic            cpu_last;
    logic [1:0]      cpu_id;
    logic            flatten;
    logic [7:0]      pci_gnt;
    pci_id_t         pci_last;
    logic [3:0]      pci_swap;
    pci_lock_state_t lock_st;
    pci_id_t         lock_owner;
  } arb_state_t;

endpackage

// ---- core/pci_pick_if.sv ----
// Carrier between the control block and the PCI priority picker.
// Assumes both ends share one clock; the picker is purely combinational.
`timescale 1ns/1ps
`default_nettype none
interface pci_pick_if;
  import arb_pkg::*;
  logic [7:0] req;
  pci_order_t order;
  logic       found;
  pci_id_t    winner;
  modport chooser (output req, output order, input found, input winner);
  modport picker  (input req, input order, output found, output winner);
endinterface
`default_nettype wire

// ---- core/pci_grant_pick.sv ----
// Picks the first requesting master in a priority order list.
// Assumes the order list holds each master id exactly once.
`timescale 1ns/1ps
`default_nettype none
module pci_grant_pick
  import arb_pkg::*;
#(
  parameter int NUM_SLOTS = 8
)(
  // Order and requests in, winner out
  pci_pick_if.picker pk
);

  always_comb
  begin
    pk.found  = 1'b0;
    pk.winner = 3'h0;
    // Scan from the lowest slot last so it takes precedence
    for (int k = NUM_SLOTS - 1; k >= 0; k--)
    begin
      if (pk.req[pk.order[k]])
      begin
        pk.found  = 1'b1;
        pk.winner = pk.order[k];
      end
    end
  end

endmodule // pci_grant_pick
`default_nettype wire

// ---- core/dual_bus_arbiter_control.sv ----
// Processor-side and PCI arbiters with their shared control and status word.
// Assumes requests and bus status are synchronous to sys_clk; straps are stable at reset.
// Operation
// - Four flattening selectors, one per cycle type, applied after each completed cycle.
// - Selector 00/01 none, 10 always flatten, 11 flatten on master switch.
// - Priority bit set rotates CPU0/CPU1; clear gives CPU0 fixed precedence.
// - CPU parking: 00 none, 01 last CPU, 10 CPU0, 11 CPU1.
// - Read-only CPU arbiter active bit; writes ignored.
// - PCI scheme: 00 fixed, 01 round robin, 10 mixed, 11 reserved.
// - PCI parking: 0000 last, 0001-0111 requester 6..0, 1000 bridge, 1111 none.
// - Fixed hierarchy rotates ring requester 6 down to 0 then bridge.
// - Mixed hierarchy orders four groups; codes 100-111 reserved.
// - Park-on-lock keeps locking master granted, denies others until lock released.
// - Park-on-lock clear ignores lock entirely.
// - Read-only PCI arbiter active bit fixed by strap.
// - Current CPU data bus master id on current_cpu_master_id only: from the internal arbiter grant, or from ext_cpu_master_id when the internal arbiter is off.
`timescale 1ns/1ps
`default_nettype none
`include "arb_consts.svh"
module dual_bus_arbiter_control
  import arb_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // Configuration straps
  input  wire logic        cpu_arb_strap,
  input  wire logic        pci_arb_strap,
  // Register access
  input  wire logic        reg_cs,
  input  wire logic        reg_we,
  input  wire logic [31:0] reg_addr,
  input  wire logic [3:0]  reg_be,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  output logic             reg_ack,
  // Processor bus
  input  wire logic [1:0]  cpu_req,
  input  wire logic        bridge_cpu_req,
  input  wire logic        cpu_addr_idle,
  input  wire logic        cyc_done,
  input  wire logic        cyc_burst,
  input  wire logic        cyc_write,
  input  wire logic [1:0]  ext_cpu_master_id,
  output logic      [2:0]  cpu_gnt,
  output logic      [1:0]  current_cpu_master_id,
  output logic             cpu_flatten,
  // PCI bus
  input  wire logic [7:0]  pci_req,
  input  wire logic        pci_bus_idle,
  input  wire logic        pci_lock_active,
  output logic      [7:0]  pci_gnt
);

  arb_state_t  st_r;
  arb_state_t  st_nxt;
  pci_pick_if  pk ();

  logic [31:0] wmask;
  logic [31:0] read_word;
  logic [1:0]  flat_sel;
  logic [1:0]  cpu_prk;
  logic        cpu_pri;
  logic [1:0]  pci_sch;
  logic [3:0]  pci_prk;
  logic [2:0]  pci_priority_order_code;
  logic        pci_pol;
  logic        use_fixed;
  logic [2:0]  eff_priority_order_code;

  pci_grant_pick #(
    .NUM_SLOTS (8)
  ) u_pick (
    .pk (pk.picker)
  );

  // Ring position to master id and back; the map is its own inverse
  function automatic pci_id_t ring_map(input pci_id_t v);
    ring_map = (v == `PCI_RING_TOP) ? `PCI_BRIDGE_ID : 3'(3'h6 - v);
  endfunction

  function automatic pci_id_t enc8(input logic [7:0] oh);
    enc8 = 3'h0;
    for (int i = 0; i < 8; i++)
    begin
      if (oh[i])
      begin
        enc8 = 3'(i);
      end
    end
  endfunction

  assign wmask    = {{8{reg_be[3]}}, {8{reg_be[2]}}, {8{reg_be[1]}}, {8{reg_be[0]}}}
                    & `ARB_RW_MASK;
  assign cpu_pri  = st_r.cfg[`CPU_PRI_POS];
  assign cpu_prk  = st_r.cfg[`CPU_PRK_POS +: 2];
  assign pci_sch  = st_r.cfg[`PCI_SCH_POS +: 2];
  assign pci_prk  = st_r.cfg[`PCI_PRK_POS +: 4];
  assign pci_priority_order_code = st_r.cfg[`PCI_PRIORITY_ORDER_CODE_POS +: 3];
  assign pci_pol  = st_r.cfg[`PCI_POL_POS];
  // Active bits are not stored in the writable image, so writes cannot touch them
  assign read_word = st_r.cfg | (32'(st_r.cpu_ena) << `CPU_ENA_POS)
                     | (32'(st_r.pci_ena) << `PCI_ENA_POS);

  // Selector for the cycle type that just completed
  assign flat_sel = cyc_burst ? (cyc_write ? st_r.cfg[`FBW_POS +: 2] : st_r.cfg[`FBR_POS +: 2])
                              : (cyc_write ? st_r.cfg[`FSW_POS +: 2]
                                           : st_r.cfg[`FSR_POS +: 2]);

  // Reserved scheme, or reserved mixed hierarchy, degrades to fixed with code 000
  assign use_fixed = (pci_sch == `PCI_SCH_FIXED) || (pci_sch == `PCI_SCH_RSVD)
                     || ((pci_sch == `PCI_SCH_MIXED) && pci_priority_order_code[2]);
  assign eff_priority_order_code  = (pci_sch == `PCI_SCH_FIXED) ? pci_priority_order_code : 3'h0;

  // Priority order list for the picker
  always_comb
  begin
    pci_id_t  p;
    logic [1:0] g;
    logic [1:0] sg;
    p  = 3'h0;
    g  = 2'h0;
    sg = 2'(2'h0 - pci_priority_order_code[1:0]);
    pk.req = pci_req;
    for (int k = 0; k < 8; k++)
    begin
      if (use_fixed)
      begin
        p = 3'(3'h0 - eff_priority_order_code + 3'(k));
      end
      else if (pci_sch == `PCI_SCH_RR)
      begin
        p = 3'(ring_map(st_r.pci_last) + 3'h1 + 3'(k));
      end
      else
      begin
        g = 2'(sg + 2'(k / 2));
        p = {g, 1'(k % 2) ^ st_r.pci_swap[g]};
      end
      pk.order[k] = ring_map(p);
    end
  end

  always_comb
  begin
    logic [1:0] cw;
    logic       cv;
    logic       by_req;
    pci_id_t    pw;
    pci_id_t    wpos;
    cw     = 2'h0;
    cv     = 1'b1;
    by_req = 1'b1;
    pw     = 3'h0;
    wpos   = 3'h0;
    st_nxt = st_r;
    st_nxt.ack = 1'b0;

    // Straps are caught on the first cycle after reset release
    if (!st_r.strap_done)
    begin
      st_nxt.cpu_ena    = cpu_arb_strap;
      st_nxt.pci_ena    = pci_arb_strap;
      st_nxt.strap_done = 1'b1;
    end

    // Register word: unmapped reads return zero, unmapped writes are dropped
    if (reg_cs)
    begin
      st_nxt.ack = 1'b1;
      if (reg_addr == `ARB_WORD_ADDR)
      begin
        if (reg_we)
          st_nxt.cfg = (st_r.cfg & ~wmask) | (reg_wdata & wmask);
        else
          st_nxt.rdata = read_word;
      end
      else if (!reg_we)
        st_nxt.rdata = 32'h0;
    end

    // Processor-side arbitration
    if (cpu_req == 2'h3)
      cw = (cpu_pri && !st_r.cpu_last) ? 2'h1 : 2'h0;
    else if (cpu_req[0])
      cw = 2'h0;
    else if (cpu_req[1])
      cw = 2'h1;
    else if (bridge_cpu_req)
      cw = 2'h2;
    else
    begin
      by_req = 1'b0;
      case (cpu_prk)
        `CPU_PARK_NONE: cv = 1'b0;
        `CPU_PARK_LAST: cw = {1'b0, st_r.cpu_last};
        `CPU_PARK_CPU0: cw = 2'h0;
        default:        cw = 2'h1;
      endcase
    end
    // Grants only move between address tenures
    if (!st_r.cpu_ena)
      st_nxt.cpu_gnt = 3'h0;
    else if (cpu_addr_idle)
    begin
      st_nxt.cpu_gnt = cv ? 3'(3'h1 << cw) : 3'h0;
      if (by_req && !cw[1])
        st_nxt.cpu_last = cw[0];
    end
    if (!st_r.cpu_ena)
      st_nxt.cpu_id = ext_cpu_master_id;
    else if (st_nxt.cpu_gnt != 3'h0)
      st_nxt.cpu_id = st_nxt.cpu_gnt[2] ? 2'h2 : {1'b0, st_nxt.cpu_gnt[1]};
    st_nxt.flatten = cyc_done && ((flat_sel == `FLAT_ALWAYS)
                     || ((flat_sel == `FLAT_SWITCH)
                         && (st_nxt.cpu_gnt != st_r.cpu_gnt)));

    // PCI arbitration
    if (!st_r.pci_ena)
    begin
      st_nxt.pci_gnt = 8'h00;
      st_nxt.lock_st = PCI_FREE;
    end
    else
    begin
      case (st_r.lock_st)
        PCI_LOCKED:
        begin
          // Others are shut out while the lock stands
          st_nxt.pci_gnt = 8'(8'h01 << st_r.lock_owner);
          if (!pci_lock_active || !pci_pol)
            st_nxt.lock_st = PCI_FREE;
        end
        default:
        begin
          if (pci_pol && pci_lock_active && (st_r.pci_gnt != 8'h00))
          begin
            st_nxt.lock_st    = PCI_LOCKED;
            st_nxt.lock_owner = enc8(st_r.pci_gnt);
          end
          else if (pci_bus_idle)
          begin
            // Lock state plays no part here when park-on-lock is clear
            if (pk.found)
            begin
              wpos = ring_map(pk.winner);
              st_nxt.pci_gnt = 8'(8'h01 << pk.winner);
              st_nxt.pci_last = pk.winner;
              st_nxt.pci_swap[wpos[2:1]] = ~wpos[0];
            end
            else
            begin
              if (pci_prk == `PCI_PARK_LAST)
                st_nxt.pci_gnt = 8'(8'h01 << st_r.pci_last);
              else if (pci_prk < `PCI_PARK_BRIDGE)
              begin
                pw = 3'(4'h7 - pci_prk);
                st_nxt.pci_gnt = 8'(8'h01 << pw);
              end
              else if (pci_prk == `PCI_PARK_BRIDGE)
                st_nxt.pci_gnt = 8'(8'h01 << `PCI_BRIDGE_ID);
              else
                st_nxt.pci_gnt = 8'h00;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      st_r <= '{cfg: `ARB_RESET_CFG, lock_st: PCI_FREE, default: '0};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata             = st_r.rdata;
  assign reg_ack               = st_r.ack;
  assign cpu_gnt               = st_r.cpu_gnt;
  assign current_cpu_master_id = st_r.cpu_id;
  assign cpu_flatten           = st_r.flatten;
  assign pci_gnt               = st_r.pci_gnt;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  flatten_always_a: assert property (
    cyc_done && !cyc_burst && !cyc_write && (st_r.cfg[`FSR_POS +: 2] == 2'h2) |=> cpu_flatten)
    else $error("single read flatten not raised");
  flatten_none_a: assert property (
    cyc_done && !flat_sel[1] |=> !cpu_flatten)
    else $error("flatten raised for a none code");
  cpu_fixed_prio_a: assert property (
    st_r.cpu_ena && cpu_addr_idle && !cpu_pri && (cpu_req == 2'h3) |=> cpu_gnt == 3'h1)
    else $error("cpu0 did not win fixed priority");
  cpu_rotate_a: assert property (
    st_r.cpu_ena && cpu_addr_idle && cpu_pri && (cpu_req == 2'h3) && !st_r.cpu_last
    |=> cpu_gnt == 3'h2)
    else $error("rotation did not pass to cpu1");
  cpu_park_a: assert property (
    st_r.cpu_ena && cpu_addr_idle && (cpu_req == 2'h0) && !bridge_cpu_req
    && (cpu_prk == `CPU_PARK_CPU1) |=> cpu_gnt == 3'h2)
    else $error("bus not parked on cpu1");
  cpu_ena_ro_a: assert property (
    st_r.strap_done |=> $stable(st_r.cpu_ena) && $stable(st_r.pci_ena))
    else $error("arbiter active bit changed after reset");
  pci_park_bridge_a: assert property (
    st_r.pci_ena && (st_r.lock_st == PCI_FREE) && pci_bus_idle && !pci_lock_active
    && (pci_req == 8'h00) && (pci_prk == `PCI_PARK_BRIDGE) |=> pci_gnt == 8'h80)
    else $error("bus not parked on bridge");
  pci_fixed_top_a: assert property (
    st_r.pci_ena && (st_r.lock_st == PCI_FREE) && pci_bus_idle && !pci_lock_active
    && (pci_sch == `PCI_SCH_FIXED) && (pci_priority_order_code == 3'h1) && pci_req[7] |=> pci_gnt == 8'h80)
    else $error("bridge not highest under hierarchy 001");
  pci_lock_hold_a: assert property (
    (st_r.lock_st == PCI_LOCKED) && pci_lock_active && pci_pol |=> $stable(pci_gnt))
    else $error("grant moved while locked");
  pci_reserved_a: assert property (
    st_r.pci_ena && (st_r.lock_st == PCI_FREE) && pci_bus_idle && !pci_lock_active
    && (pci_sch == `PCI_SCH_RSVD) && pci_req[6] |=> pci_gnt == 8'h40)
    else $error("reserved scheme did not fall back to fixed");
  cpu_master_id_a: assert property (
    st_r.cpu_ena && cpu_gnt[1] |-> current_cpu_master_id == 2'h1)
    else $error("master id does not follow grant");

endmodule // dual_bus_arbiter_control
`default_nettype wire

// ---- verif/bus_masters_model.sv ----
// Requesting masters on the processor bus and the PCI bus.
// Assumes the bench sets the wishes; requests move on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module bus_masters_model (
  // Clock
  input  wire logic       sys_clk,
  // Bench wishes
  input  wire logic [2:0] want_cpu,
  input  wire logic [7:0] want_pci,
  input  wire logic       want_lock,
  // Grant seen
  input  wire logic [7:0] pci_gnt,
  // Requests out
  output logic      [1:0] cpu_req,
  output logic            bridge_cpu_req,
  output logic      [7:0] pci_req,
  output logic            pci_lock_active
);
  initial
  begin
    cpu_req         = 2'h0;
    bridge_cpu_req  = 1'b0;
    pci_req         = 8'h00;
    pci_lock_active = 1'b0;
  end

  // A lock can only be taken by a master that holds the bus
  always @(negedge sys_clk)
  begin
    cpu_req         <= want_cpu[1:0];
    bridge_cpu_req  <= want_cpu[2];
    pci_req         <= want_pci;
    pci_lock_active <= want_lock & (|pci_gnt);
  end
endmodule // bus_masters_model
`default_nettype wire

// ---- verif/dual_bus_arbiter_control_tb.sv ----
// Self-checking bench for the dual arbiter control block.
// Assumes straps start high and drop for a late second reset; the masters model makes the requests.
`timescale 1ns/1ps
`default_nettype none
`include "arb_consts.svh"
module dual_bus_arbiter_control_tb;
  logic        sys_clk, srst, reg_cs, reg_we, reg_ack, want_lock;
  logic        cyc_done, cyc_burst, cyc_write, bridge_cpu_req;
  logic        cpu_flatten, pci_lock_active;
  logic        cpu_strap, pci_strap;
  logic [31:0] reg_addr, reg_wdata, reg_rdata;
  logic [3:0]  reg_be;
  logic [2:0]  want_cpu, cpu_gnt;
  logic [1:0]  cpu_req, cpu_id;
  logic [7:0]  want_pci, pci_req, pci_gnt, g1, ex;
  int          errors, samples_checked, cycles;
  localparam logic [31:0] A = `ARB_WORD_ADDR;

  dual_bus_arbiter_control i_dut (.sys_clk(sys_clk), .srst(srst),
    .cpu_arb_strap(cpu_strap), .pci_arb_strap(pci_strap), .reg_cs(reg_cs),
    .reg_we(reg_we), .reg_addr(reg_addr), .reg_be(reg_be),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .cpu_req(cpu_req), .bridge_cpu_req(bridge_cpu_req),
    .cpu_addr_idle(1'b1), .cyc_done(cyc_done), .cyc_burst(cyc_burst),
    .cyc_write(cyc_write), .ext_cpu_master_id(2'h0), .cpu_gnt(cpu_gnt),
    .current_cpu_master_id(cpu_id), .cpu_flatten(cpu_flatten),
    .pci_req(pci_req), .pci_bus_idle(1'b1),
    .pci_lock_active(pci_lock_active), .pci_gnt(pci_gnt));

  bus_masters_model i_masters (.sys_clk(sys_clk), .want_cpu(want_cpu),
    .want_pci(want_pci), .want_lock(want_lock), .pci_gnt(pci_gnt),
    .cpu_req(cpu_req), .bridge_cpu_req(bridge_cpu_req),
    .pci_req(pci_req), .pci_lock_active(pci_lock_active));

  always #25 sys_clk = ~sys_clk;

  task automatic end_sim;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic chk_gnt(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: grant %h, wanted %h", $time, got, exp);
    end
  endtask

  // One access per call; strobe drops before the next call raises it
  task automatic acc(input logic we, input logic [31:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    @(negedge sys_clk);
    reg_cs    = 1'b1;
    reg_we    = we;
    reg_addr  = a;
    reg_wdata = d;
    reg_be    = be;
    @(posedge sys_clk);
    #1;
    chk_gnt({7'h00, reg_ack}, 8'h01);
    @(negedge sys_clk);
    reg_cs = 1'b0;
  endtask

  task automatic wr(input logic [31:0] d);
    acc(1'b1, A, d, 4'hF);
  endtask

  task automatic rd(input logic [31:0] exp);
    acc(1'b0, A, 32'h0, 4'h0);
    chk_word(reg_rdata, exp);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Pulse one completed cycle: 0 burst read, 1 single read, 2 burst write, 3 single write
  task automatic cyc(input int u, input logic exp);
    @(negedge sys_clk);
    cyc_done  = 1'b1;
    cyc_burst = (u % 2 == 0);
    cyc_write = (u >= 2);
    @(posedge sys_clk);
    #1;
    chk_gnt({7'h00, cpu_flatten}, {7'h00, exp});
    @(negedge sys_clk);
    cyc_done = 1'b0;
  endtask

  // A hang counts as a mismatch and still reaches the verdict
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      end_sim();
    end
  end

  initial
  begin
    {sys_clk, reg_cs, reg_we, cyc_done, cyc_burst, cyc_write, want_lock} = '0;
    {reg_addr, reg_wdata, reg_be, want_cpu, want_pci} = '0;
    {errors, samples_checked, cycles} = '0;
    {cpu_strap, pci_strap} = 2'b11;
    srst = 1'b1;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    srst = 1'b0;
    wt(2);
    rd(32'h00010001);
    wr(32'hFFFFFFFF);
    rd(`ARB_RW_MASK | 32'h00010001);
    wr(32'h00000000);
    acc(1'b1, A + 32'h4, 32'hFFFFFFFF, 4'hF);
    rd(32'h00010001);
    acc(1'b0, A + 32'h4, 32'h0, 4'h0);
    chk_word(reg_rdata, 32'h00000000);
    acc(1'b1, A, 32'hFFFFFFFF, 4'h2);
    rd(32'h0001FF01);
    wr(32'h00000000);
    // Processor side: fixed then rotating priority, then master id
    want_cpu = 3'b011;
    wt(3);
    chk_gnt({5'h00, cpu_gnt}, 8'h01);
    chk_gnt({6'h00, cpu_id}, 8'h00);
    wr(32'h00400000);
    wt(1);
    g1 = {5'h00, cpu_gnt};
    wt(1);
    chk_gnt(g1 ^ {5'h00, cpu_gnt}, 8'h03);
    wr(32'h00000000);
    want_cpu = 3'b100;
    wt(3);
    chk_gnt({6'h00, cpu_id}, 8'h02);
    want_cpu = 3'b010;
    wt(3);
    chk_gnt({6'h00, cpu_id}, 8'h01);
    want_cpu = 3'b000;
    // Idle grant for each parking code; last CPU was CPU1
    for (int k = 0; k < 4; k++)
    begin
      wr(32'(k) << 20);
      wt(3);
      ex = (k == 0) ? 8'h00 : (k == 2) ? 8'h01 : 8'h02;
      chk_gnt({5'h00, cpu_gnt}, ex);
    end
    wr(32'h00000000);
    // Same code in all four selectors, no master switch
    for (int c = 0; c < 4; c++)
    begin
      wr(32'(c) * 32'h55000000);
      cyc(c, c == 2);
    end
    // Each selector acts only on its own cycle type
    for (int t = 0; t < 4; t++)
    begin
      wr(32'h2 << (30 - 2 * t));
      for (int u = 0; u < 4; u++)
        cyc(u, u == t);
    end
    // Code 11 under rotating priority: the grant moves every cycle
    want_cpu = 3'b011;
    wr(32'hFF400000);
    cyc(3, 1'b1);
    // PCI fixed ring for every hierarchy code
    want_pci = 8'hFF;
    for (int h = 0; h < 8; h++)
    begin
      wr(32'(h) << 7);
      wt(3);
      ex = ((8 - h) % 8 < 7) ? 8'h01 << (6 - (8 - h) % 8) : 8'h80;
      chk_gnt(pci_gnt, ex);
    end
    wr(32'h0000C180);
    wt(3);
    chk_gnt(pci_gnt, 8'h40);
    wr(32'h00008200);
    wt(3);
    chk_gnt(pci_gnt, 8'h40);
    wr(32'h00008080);
    wt(3);
    chk_gnt({7'h00, |(pci_gnt & 8'h81)}, 8'h01);
    wr(32'h00004000);
    wt(2);
    g1 = pci_gnt;
    wt(1);
    ex = (g1 == 8'h80) ? 8'h40 : (g1 == 8'h01) ? 8'h80 : g1 >> 1;
    chk_gnt(pci_gnt, ex);
    // PCI parking: last master, then each fixed target, then none
    wr(32'h00000000);
    want_pci = 8'h04;
    wt(3);
    want_pci = 8'h00;
    wt(3);
    chk_gnt(pci_gnt, 8'h04);
    for (int k = 1; k < 10; k++)
    begin
      wr(32'((k == 9) ? 15 : k) << 10);
      wt(3);
      ex = (k < 8) ? 8'h01 << (7 - k) : (k == 8) ? 8'h80 : 8'h00;
      chk_gnt(pci_gnt, ex);
    end
    // Locked master keeps the bus only while park-on-lock is set
    for (int p = 1; p >= 0; p--)
    begin
      wr(32'(p) << 6);
      want_pci = 8'h01;
      wt(3);
      want_lock = 1'b1;
      wt(3);
      want_pci = 8'hFF;
      wt(3);
      chk_gnt(pci_gnt, (p == 1) ? 8'h01 : 8'h40);
      want_lock = 1'b0;
      wt(4);
      chk_gnt(pci_gnt, 8'h40);
    end
    // Straps low through a second reset: both arbiters off, status bits clear
    @(negedge sys_clk);
    want_cpu = 3'b011;
    {cpu_strap, pci_strap, srst} = 3'b001;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    srst = 1'b0;
    wt(3);
    rd(32'h00000000);
    chk_gnt({5'h00, cpu_gnt}, 8'h00);
    chk_gnt(pci_gnt, 8'h00);
    end_sim();
  end
endmodule // dual_bus_arbiter_control_tb
`default_nettype wire
